/* File: eil_pkg.sv */
/*
 Shared constants for the event interrupt logic: register indices, field
 positions, reset values and source bit assignments.
 Assumes a classic Wishbone slave with 32-bit data, where register index N
 sits at byte address 4*N.
*/
// Contract
// - Each request output is an active-low open-drain driver, released high by an external pull-up.
// - Ten event flag bits live in two flag registers at indices 0x05 and 0x06, one per monitored condition.
// - Each flag has its own enable bit, held in two enable registers at indices 0x03 and 0x04.
// - With its enable high, a flag latches on a rising source edge and drives its assigned request output.
// - With its enable low, a flag reads back the live source level and never affects a request output.
// - The host clears a latched flag by writing a one to its bit position.
// - Hardware reset and software reset both clear every latched flag.
// - Routing registers at indices 0x07 and 0x08 send each flag to the first output (0) or second (1).
// - Both request outputs behave alike, active while any enabled latched flag routed to them is set.
// - Writing a flag bit also clears the underlying source when that source is itself latched.
// - Monitored sources include at least the PLL lock indication and the FIFO level warning.
package eil_pkg;
    localparam int NFLAG = 10;
    localparam int ADR_W = 6;
    localparam logic [3:0] IDX_ENA_LO = 4'h3;
    localparam logic [3:0] IDX_ENA_HI = 4'h4;
    localparam logic [3:0] IDX_EVT_LO = 4'h5;
    localparam logic [3:0] IDX_EVT_HI = 4'h6;
    localparam logic [3:0] IDX_RTE_LO = 4'h7;
    localparam logic [3:0] IDX_RTE_HI = 4'h8;
    localparam logic [3:0] IDX_STS = 4'h9;
    localparam logic [3:0] IDX_MSK = 4'hA;
    localparam logic [3:0] IDX_CTL = 4'hB;
    localparam int CTL_SOFT_RST = 0;
    localparam int SRC_PLL_LOCK = 0;
    localparam int SRC_FIFO_WARN = 1;
    localparam logic [9:0] RST_FLAGS = 10'h000;
    localparam logic [9:0] RST_ENABLE = 10'h000;
    localparam logic [9:0] RST_ROUTE = 10'h000;
    localparam logic [9:0] RST_MASK = 10'h000;
    localparam logic [9:0] DFLT_LATCHED_SRC = 10'h3FE;
endpackage

/* File: eil_sync.sv */
/*
 Three-stage synchroniser with agreement filter for a group of level inputs.
 Assumes inputs are asynchronous to mclk; the output level changes only when
 stages two and three agree.
*/
`timescale 1ns/100ps
`default_nettype none
module eil_sync #(
    parameter int W = 10
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [W-1:0] async_in,
    output logic [W-1:0] level
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] lvl;
    } eil_sync_type;

    eil_sync_type st_ff;
    eil_sync_type nxt_st;

    always_comb begin
        nxt_st = st_ff;
        nxt_st.s1 = async_in;
        nxt_st.s2 = st_ff.s1;
        nxt_st.s3 = st_ff.s2;
        // Accept a new level only once two late stages match
        for (int i = 0; i < W; i++) begin
            if (st_ff.s2[i] == st_ff.s3[i]) begin
                nxt_st.lvl[i] = st_ff.s3[i];
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign level = st_ff.lvl;
endmodule
`default_nettype wire

/* File: eil_top.sv */
/*
 Event flag and interrupt request logic with a classic Wishbone slave.
 Assumes src_in levels are asynchronous, the request pins are pulled up
 outside and wired-OR, and the bus master holds a request until ack.
*/
`timescale 1ns/100ps
`default_nettype none
module eil_top #(
    parameter logic [9:0] LATCHED_SRC = eil_pkg::DFLT_LATCHED_SRC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [eil_pkg::ADR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [eil_pkg::NFLAG-1:0] src_in,
    output logic [eil_pkg::NFLAG-1:0] src_clear,
    input wire logic request_out_first_in,
    output logic request_out_first_out,
    output logic request_out_first_oe,
    input wire logic request_out_second_in,
    output logic request_out_second_out,
    output logic request_out_second_oe,
    output logic irq
);
    typedef struct packed {
        logic [9:0] latch;
        logic [9:0] enable;
        logic [9:0] route;
        logic [9:0] ists;
        logic [9:0] imask;
        logic [9:0] prev;
        logic [9:0] clr;
        logic soft_rst;
        logic ack;
        logic [31:0] rdata;
    } eil_state_type;

    localparam eil_state_type ST_RST = '{
        latch: eil_pkg::RST_FLAGS,
        enable: eil_pkg::RST_ENABLE,
        route: eil_pkg::RST_ROUTE,
        ists: 10'h000,
        imask: eil_pkg::RST_MASK,
        prev: 10'h000,
        clr: 10'h000,
        soft_rst: 1'b0,
        ack: 1'b0,
        rdata: 32'h0000_0000
    };

    eil_state_type st_ff;
    eil_state_type nxt_st;
    logic [9:0] lvl;
    logic [9:0] rise;
    logic [9:0] set_v;
    logic [9:0] flags_rd;
    logic [9:0] wclr;
    logic [9:0] lane;
    logic [3:0] idx;
    logic acc;
    logic wr;
    logic aligned;
    logic req_first;
    logic req_second;

    // Replace the low byte or the top two bits of a 10-bit field
    function automatic logic [9:0] put_half(input logic [9:0] old, input logic hi,
                                            input logic [7:0] d);
        put_half = hi ? {d[1:0], old[7:0]} : {old[9:8], d};
    endfunction

    // Place a byte at the low byte or top two bits of a 10-bit vector
    function automatic logic [9:0] at_half(input logic hi, input logic [7:0] d);
        at_half = hi ? {d[1:0], 8'h00} : {2'b00, d};
    endfunction

    eil_sync #(
        .W(eil_pkg::NFLAG)
    ) u_sync (
        .mclk(mclk),
        .srst(srst),
        .async_in(src_in),
        .level(lvl)
    );

    assign idx = wb_adr_i[5:2];
    assign aligned = (wb_adr_i[1:0] == 2'b00);
    assign acc = wb_cyc_i & wb_stb_i;
    // Writes land on the edge where the master samples ack
    assign wr = acc & st_ff.ack & wb_we_i & aligned;
    assign lane = {{2{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign rise = lvl & ~st_ff.prev;
    assign set_v = rise & st_ff.enable;
    assign flags_rd = (st_ff.enable & st_ff.latch) | (~st_ff.enable & lvl);

    always_comb begin
        wclr = 10'h000;
        if (wr && wb_sel_i[0] && (idx == eil_pkg::IDX_EVT_LO)) begin
            wclr = at_half(1'b0, wb_dat_i[7:0]);
        end else if (wr && wb_sel_i[0] && (idx == eil_pkg::IDX_EVT_HI)) begin
            wclr = at_half(1'b1, wb_dat_i[7:0]);
        end
    end

    always_comb begin
        nxt_st = st_ff;
        nxt_st.ack = acc & ~st_ff.ack;
        nxt_st.prev = lvl;
        nxt_st.soft_rst = 1'b0;
        // Source rising edge wins over a same-cycle clear
        nxt_st.latch = (st_ff.latch & ~wclr & {10{~st_ff.soft_rst}}) | set_v;
        nxt_st.clr = wclr & LATCHED_SRC;
        nxt_st.ists = st_ff.ists | rise;
        if (wr && wb_sel_i[0]) begin
            case (idx)
                eil_pkg::IDX_ENA_LO: nxt_st.enable = put_half(st_ff.enable, 1'b0, wb_dat_i[7:0]);
                eil_pkg::IDX_ENA_HI: nxt_st.enable = put_half(st_ff.enable, 1'b1, wb_dat_i[7:0]);
                eil_pkg::IDX_RTE_LO: nxt_st.route = put_half(st_ff.route, 1'b0, wb_dat_i[7:0]);
                eil_pkg::IDX_RTE_HI: nxt_st.route = put_half(st_ff.route, 1'b1, wb_dat_i[7:0]);
                eil_pkg::IDX_CTL: nxt_st.soft_rst = wb_dat_i[eil_pkg::CTL_SOFT_RST];
                default: nxt_st.route = st_ff.route;
            endcase
        end
        if (wr && (idx == eil_pkg::IDX_STS)) begin
            nxt_st.ists = (st_ff.ists & ~(wb_dat_i[9:0] & lane)) | rise;
        end
        if (wr && (idx == eil_pkg::IDX_MSK)) begin
            nxt_st.imask = (st_ff.imask & ~lane) | (wb_dat_i[9:0] & lane);
        end
        if (acc && !st_ff.ack) begin
            nxt_st.rdata = 32'h0000_0000;
            if (aligned) begin
                case (idx)
                    eil_pkg::IDX_ENA_LO: nxt_st.rdata[7:0] = st_ff.enable[7:0];
                    eil_pkg::IDX_ENA_HI: nxt_st.rdata[1:0] = st_ff.enable[9:8];
                    eil_pkg::IDX_EVT_LO: nxt_st.rdata[7:0] = flags_rd[7:0];
                    eil_pkg::IDX_EVT_HI: nxt_st.rdata[1:0] = flags_rd[9:8];
                    eil_pkg::IDX_RTE_LO: nxt_st.rdata[7:0] = st_ff.route[7:0];
                    eil_pkg::IDX_RTE_HI: nxt_st.rdata[1:0] = st_ff.route[9:8];
                    eil_pkg::IDX_STS: nxt_st.rdata[9:0] = st_ff.ists;
                    eil_pkg::IDX_MSK: nxt_st.rdata[9:0] = st_ff.imask;
                    default: nxt_st.rdata = 32'h0000_0000;
                endcase
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (srst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // Only enabled latched flags reach a pin, split by route bit
    assign req_first = |(st_ff.latch & st_ff.enable & ~st_ff.route);
    assign req_second = |(st_ff.latch & st_ff.enable & st_ff.route);
    // Open drain: pull low when active, else release
    assign request_out_first_out = 1'b0;
    assign request_out_first_oe = req_first;
    assign request_out_second_out = 1'b0;
    assign request_out_second_oe = req_second;
    assign src_clear = st_ff.clr;
    assign wb_dat_o = st_ff.rdata;
    assign wb_ack_o = st_ff.ack;
    assign irq = |(st_ff.ists & st_ff.imask);

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (srst);

    logic [7:0] lvl_lo;
    logic [1:0] lvl_hi;
    logic [7:0] wdat_lo;
    assign lvl_lo = lvl[7:0];
    assign lvl_hi = lvl[9:8];
    assign wdat_lo = wb_dat_i[7:0];

    chk_od_low: assert property (!request_out_first_out && !request_out_second_out)
        else $error("Request output drives high");
    chk_flag_latch: assert property (|set_v |=> ((st_ff.latch & $past(set_v)) == $past(set_v)))
        else $error("Enabled flag did not latch on source edge");
    chk_flag_hold: assert property (st_ff.latch[0] && st_ff.enable[0] && !wclr[0]
        && !st_ff.soft_rst |=> st_ff.latch[0])
        else $error("Latched flag dropped without clear");
    chk_live_read: assert property (acc && !st_ff.ack && aligned && idx == eil_pkg::IDX_EVT_LO
        && st_ff.enable[7:0] == 8'h00 |=> wb_dat_o[7:0] == $past(lvl_lo))
        else $error("Disabled flags did not read live source");
    chk_dis_quiet: assert property (st_ff.enable == 10'h000 |-> !request_out_first_oe
        && !request_out_second_oe)
        else $error("Request active with all flags disabled");
    chk_w1c_clear: assert property (wclr[0] && !set_v[0] |=> !st_ff.latch[0])
        else $error("Write one did not clear flag");
    chk_soft_clear: assert property (st_ff.soft_rst && set_v == 10'h000 |=> st_ff.latch == 10'h000)
        else $error("Software reset left a flag latched");
    chk_route_pin: assert property (st_ff.latch[1] && st_ff.enable[1] |-> (st_ff.route[1] ?
        request_out_second_oe : request_out_first_oe))
        else $error("Flag not routed to selected output");
    chk_any_flag: assert property (!req_first && !req_second |-> (st_ff.latch & st_ff.enable) == 10'h000)
        else $error("Outputs idle while a flag is active");
    chk_src_clr: assert property (wclr[9] && LATCHED_SRC[9] |=> src_clear[9] ##1 !src_clear[9])
        else $error("Latched source clear not pulsed once");
    chk_edge_once: assert property (rise[eil_pkg::SRC_FIFO_WARN] |=> !rise[eil_pkg::SRC_FIFO_WARN])
        else $error("One source edge seen twice");
    chk_ack_pulse: assert property (acc && !st_ff.ack |=> wb_ack_o ##1 !wb_ack_o)
        else $error("Ack not a single cycle");
    chk_ena_write: assert property (wr && wb_sel_i[0] && idx == eil_pkg::IDX_ENA_LO
        |=> st_ff.enable[7:0] == $past(wdat_lo))
        else $error("Enable write did not land");
    chk_route_write: assert property (wr && wb_sel_i[0] && idx == eil_pkg::IDX_RTE_LO
        |=> st_ff.route[7:0] == $past(wdat_lo))
        else $error("Route write did not land");
    chk_live_high: assert property (acc && !st_ff.ack && aligned && idx == eil_pkg::IDX_EVT_HI
        && st_ff.enable[9:8] == 2'b00 |=> wb_dat_o[1:0] == $past(lvl_hi))
        else $error("Disabled upper flags did not read live source");
    chk_src_cause: assert property (src_clear != 10'h000 |-> $past(wr))
        else $error("Source clear without a flag write");
    chk_soft_pulse: assert property (st_ff.soft_rst |=> !st_ff.soft_rst)
        else $error("Software reset did not self clear");
    chk_first_pin: assert property (st_ff.latch[0] && st_ff.enable[0] && !st_ff.route[0]
        |-> request_out_first_oe)
        else $error("First output idle with a routed flag set");

    cov_pll_set: cover property (set_v[eil_pkg::SRC_PLL_LOCK]);
    cov_second_req: cover property (request_out_second_oe);
    cov_w1c: cover property (wclr != 10'h000);
    cov_irq: cover property ($rose(irq));
    cov_src_clear: cover property (src_clear != 10'h000);
endmodule
`default_nettype wire

/* File: eil_src_model.sv */
/*
 Model of the monitored sources: bit 0 follows its drive level, the others
 latch on a drive pulse and hold until the block pulses src_clear.
 Assumes drive changes just after rising mclk edges.
*/
`timescale 1ns/100ps
`default_nettype none
module eil_src_model #(
    parameter logic [9:0] LATCHED = eil_pkg::DFLT_LATCHED_SRC
) (
    input wire logic mclk,
    input wire logic srst,
    input wire logic [9:0] drive,
    input wire logic [9:0] src_clear,
    output logic [9:0] src_in
);
    logic [9:0] held_ff;
    always_ff @(posedge mclk) begin
        if (srst) begin
            held_ff <= 10'h000;
        end else begin
            held_ff <= (held_ff | drive) & ~src_clear;
        end
    end
    assign src_in = (held_ff & LATCHED) | (drive & ~LATCHED);
endmodule
`default_nettype wire

/* File: tb.sv */
/*
 Self-checking bench for the event interrupt logic over classic Wishbone.
 Assumes the request pins are pulled up outside and mclk runs at 20 MHz.
*/
`timescale 1ns/100ps
`default_nettype none
module tb;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, oe1, oe2, out1, out2, irq;
    logic [5:0] adr = 6'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0, rdat, dat_o;
    logic [9:0] drv = 10'h000, src, clr;
    wire logic pin1 = oe1 ? out1 : 1'b1;
    wire logic pin2 = oe2 ? out2 : 1'b1;
    int error_cnt = 0, samples_checked = 0;
    initial begin
        forever #25 mclk = ~mclk;
    end
    eil_top eil_top_inst (.mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
        .wb_ack_o(ack), .src_in(src), .src_clear(clr), .request_out_first_in(pin1),
        .request_out_first_out(out1), .request_out_first_oe(oe1),
        .request_out_second_in(pin2), .request_out_second_out(out2),
        .request_out_second_oe(oe2), .irq(irq));
    eil_src_model eil_src_model_inst (.mclk(mclk), .srst(srst), .drive(drv),
        .src_clear(clr), .src_in(src));
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            $display("Error at %0t: got %h expected %h", $time, got, exp);
            error_cnt++;
        end
    endtask
    task automatic bus(input logic w, input logic [3:0] idx, input logic [31:0] d);
        @(posedge mclk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= d;
        sel <= 4'h3;
        // Hold the request until ack is seen at a rising edge
        do begin
            @(posedge mclk);
        end while (ack !== 1'b1);
        rdat = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic wr(input logic [3:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d);
    endtask
    task automatic rd(input logic [3:0] idx, input logic [31:0] exp);
        bus(1'b0, idx, 32'h0);
        check(rdat, exp);
    endtask
    task automatic pins(input logic e1, input logic e2, input logic ei);
        @(negedge mclk);
        check({29'h0, pin1, pin2, irq}, {29'h0, e1, e2, ei});
        @(posedge mclk);
    endtask
    task automatic settle();
        repeat (10) @(posedge mclk);
    endtask
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge mclk);
        error_cnt++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge mclk);
        srst <= 1'b0;
        for (int i = 3; i <= 12; i++) rd(i[3:0], 32'h0);
        wr(eil_pkg::IDX_ENA_LO, 32'hA5);
        rd(eil_pkg::IDX_ENA_LO, 32'hA5);
        wr(eil_pkg::IDX_RTE_HI, 32'hFF);
        rd(eil_pkg::IDX_RTE_HI, 32'h3);
        wr(4'hC, 32'hFF);
        rd(4'hC, 32'h0);
        wr(eil_pkg::IDX_ENA_LO, 32'h0);
        wr(eil_pkg::IDX_RTE_HI, 32'h0);
        $display("Test registers done");
        drv[0] <= 1'b1;
        settle();
        rd(eil_pkg::IDX_EVT_LO, 32'h1);
        pins(1'b1, 1'b1, 1'b0);
        drv[0] <= 1'b0;
        settle();
        rd(eil_pkg::IDX_EVT_LO, 32'h0);
        $display("Test live flag done");
        wr(eil_pkg::IDX_ENA_LO, 32'h1);
        drv[0] <= 1'b1;
        settle();
        pins(1'b0, 1'b1, 1'b0);
        wr(eil_pkg::IDX_EVT_LO, 32'h1);
        settle();
        rd(eil_pkg::IDX_EVT_LO, 32'h0);
        pins(1'b1, 1'b1, 1'b0);
        drv[0] <= 1'b0;
        settle();
        drv[0] <= 1'b1;
        settle();
        drv[0] <= 1'b0;
        settle();
        rd(eil_pkg::IDX_EVT_LO, 32'h1);
        srst <= 1'b1;
        repeat (2) @(posedge mclk);
        srst <= 1'b0;
        wr(eil_pkg::IDX_ENA_LO, 32'h1);
        rd(eil_pkg::IDX_EVT_LO, 32'h0);
        pins(1'b1, 1'b1, 1'b0);
        $display("Test latched flag done");
        wr(eil_pkg::IDX_ENA_HI, 32'h2);
        wr(eil_pkg::IDX_RTE_HI, 32'h2);
        for (int k = 0; k < 2; k++) begin
            drv[9] <= 1'b1;
            @(posedge mclk);
            drv[9] <= 1'b0;
            settle();
            pins(1'b1, 1'b0, 1'b0);
            rd(eil_pkg::IDX_EVT_HI, 32'h2);
            if (k == 1) wr(eil_pkg::IDX_CTL, 32'h1);
            if (k == 1) rd(eil_pkg::IDX_EVT_HI, 32'h0);
            wr(eil_pkg::IDX_EVT_HI, 32'h2);
            settle();
            check({22'h0, src}, 32'h0);
            rd(eil_pkg::IDX_EVT_HI, 32'h0);
            pins(1'b1, 1'b1, 1'b0);
        end
        $display("Test routing done");
        wr(eil_pkg::IDX_STS, 32'h3FF);
        wr(eil_pkg::IDX_MSK, 32'h1);
        drv[0] <= 1'b1;
        settle();
        pins(1'b0, 1'b1, 1'b1);
        wr(eil_pkg::IDX_MSK, 32'h0);
        pins(1'b0, 1'b1, 1'b0);
        wr(eil_pkg::IDX_MSK, 32'h1);
        rd(eil_pkg::IDX_STS, 32'h1);
        wr(eil_pkg::IDX_STS, 32'h1);
        pins(1'b0, 1'b1, 1'b0);
        rd(eil_pkg::IDX_STS, 32'h0);
        $display("Test interrupt done");
        rd(eil_pkg::IDX_EVT_LO, 32'h1);
        wr(eil_pkg::IDX_ENA_LO, 32'h0);
        drv[0] <= 1'b0;
        settle();
        rd(eil_pkg::IDX_EVT_LO, 32'h0);
        wr(eil_pkg::IDX_EVT_LO, 32'h1);
        wr(eil_pkg::IDX_ENA_LO, 32'h1);
        rd(eil_pkg::IDX_EVT_LO, 32'h0);
        pins(1'b1, 1'b1, 1'b0);
        $display("Test service done");
        summarize();
    end
endmodule
`default_nettype wire
